/* File: hw/sipwm_core.sv */
`timescale 1ns/1ps
// Summary of operation
// - Bits 7:5 of the phase register pick 500, 750 or 1000 kHz for codes 000, 001 and 010.
// - The phase register takes writes only while the converter is off.
// - Switching locks to the master clock on the sync line.
// - Bits 4:0 delay on-time start by the field value times 11.25 degrees.
// - The lag is measured from the rising sync edge to the on-time start.
// - At reset the rate clears; on the first edge after release the lag loads the address pins, or zero if the mode pin is low.
// - A written duty limit is never exceeded by the pwm duty cycle.
// - Inside the error window the duty follows the filter gradually.
// - With saturation on, an error outside the window forces duty to zero or the limit within one cycle.
// - The saturation enable sits in the duty-limit register.
// - The compensator is third order with four numerator and three denominator coefficients.
// - The coefficients sit in writable registers, numerators as high and low bytes.
module sipwm_core (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire sipwm_pkg::sipwm_req_s reg_req,
	output logic [7:0] reg_rdata,
	input wire logic sync_line,
	input wire logic converter_on,
	input wire logic interleave_mode_pin,
	input wire logic [4:0] addr_pins,
	input wire logic signed [7:0] err_sample,
	output logic pwm_out,
	output logic [6:0] duty_cmd
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	sipwm_pkg::sipwm_cfg_s cfg_q, cfg_d;
	logic [7:0] lim_q, lim_d;
	logic [7:0] coef_q [sipwm_pkg::NUM_COEF_BYTES];
	logic [7:0] coef_d [sipwm_pkg::NUM_COEF_BYTES];
	logic strap_done_q, strap_done_d;
	logic [7:0] rdata_q, rdata_d;
	logic [6:0] duty_q, duty_d;
	logic [3:0] cidx;
	logic [6:0] limit;
	logic coef_hit;

	assign limit = lim_q[sipwm_pkg::LIM_MSB:0];
	assign cidx = 4'(reg_req.addr - sipwm_pkg::ADDR_COEF_BASE);
	// full-width range test; the four-bit index alone would alias higher addresses onto the bank
	assign coef_hit = (reg_req.addr >= sipwm_pkg::ADDR_COEF_BASE) &&
		(reg_req.addr < sipwm_pkg::ADDR_COEF_BASE + 8'(sipwm_pkg::NUM_COEF_BYTES));

	// register writes, strap capture and read mux
	always_comb begin
		cfg_d = cfg_q;
		lim_d = lim_q;
		coef_d = coef_q;
		strap_done_d = 1'b1;
		rdata_d = 8'h00;
		if (!strap_done_q) begin
			// strap caught on the first edge after release, never under reset
			cfg_d.intl = interleave_mode_pin ? addr_pins : 5'h00;
		end else if (reg_req.wr) begin
			if (reg_req.addr == sipwm_pkg::ADDR_PHASE_CFG && !converter_on) begin
				cfg_d.rate = reg_req.wdata[sipwm_pkg::RATE_MSB:sipwm_pkg::RATE_LSB];
				cfg_d.intl = reg_req.wdata[sipwm_pkg::INTL_MSB:0];
			end
			if (reg_req.addr == sipwm_pkg::ADDR_DUTY_LIM) begin
				lim_d = reg_req.wdata;
			end
			if (coef_hit) begin
				coef_d[cidx] = reg_req.wdata;
			end
		end
		if (reg_req.addr == sipwm_pkg::ADDR_PHASE_CFG) begin
			rdata_d = cfg_q;
		end else if (reg_req.addr == sipwm_pkg::ADDR_DUTY_LIM) begin
			rdata_d = lim_q;
		end else if (reg_req.addr == sipwm_pkg::ADDR_DUTY_STAT) begin
			rdata_d = {1'b0, duty_q};
		end else if (coef_hit) begin
			rdata_d = coef_q[cidx];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= '{rate: sipwm_pkg::RATE_RESET, intl: 5'h00};
			lim_q <= sipwm_pkg::DUTY_LIM_RESET;
			coef_q <= '{default: 8'h00};
			strap_done_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			cfg_q <= cfg_d;
			lim_q <= lim_d;
			coef_q <= coef_d;
			strap_done_q <= strap_done_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// switching timebase
	// ----------------------------------------
	logic sync_prev_q, sync_prev_d;
	logic [8:0] per_q, per_d, cnt_q, cnt_d, on_q, on_d;
	logic pwm_q, pwm_d;
	logic sync_edge, cyc_start;
	logic [8:0] delay, on_len;

	assign sync_edge = sync_line & ~sync_prev_q;
	assign cyc_start = (cnt_q == 9'h000);
	assign delay = 9'((14'(per_q) * 14'(cfg_q.intl)) >> sipwm_pkg::PHASE_SHIFT);
	assign on_len = 9'((16'(per_q) * 16'(duty_q)) >> sipwm_pkg::DUTY_SHIFT);

	// counter realigned on each sync edge so every module stays locked to the master
	always_comb begin
		sync_prev_d = sync_line;
		per_d = per_q;
		unique case (cfg_q.rate)
			sipwm_pkg::RATE_500K: per_d = sipwm_pkg::PER_500K;
			sipwm_pkg::RATE_750K: per_d = sipwm_pkg::PER_750K;
			sipwm_pkg::RATE_1000K: per_d = sipwm_pkg::PER_1000K;
			default: per_d = per_q;
		endcase
		if (sync_edge) begin
			cnt_d = 9'h000;
		end else if (cnt_q >= per_q - 9'h001) begin
			cnt_d = 9'h000;
		end else begin
			cnt_d = cnt_q + 9'h001;
		end
		// on-time starts at the lag point; width follows the clamped duty
		// switching off cuts a pulse short so a restart never resumes one halfway
		if (converter_on && cnt_q == delay && on_len != 9'h000) begin
			on_d = on_len;
		end else if (converter_on && on_q != 9'h000) begin
			on_d = on_q - 9'h001;
		end else begin
			on_d = 9'h000;
		end
		pwm_d = converter_on && (on_d != 9'h000);
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_prev_q <= 1'b0;
			per_q <= sipwm_pkg::PER_500K;
			cnt_q <= 9'h000;
			on_q <= 9'h000;
			pwm_q <= 1'b0;
		end else begin
			sync_prev_q <= sync_prev_d;
			per_q <= per_d;
			cnt_q <= cnt_d;
			on_q <= on_d;
			pwm_q <= pwm_d;
		end
	end

	// ----------------------------------------
	// compensation filter
	// ----------------------------------------
	logic signed [7:0] e1_q, e2_q, e3_q, e1_d, e2_d, e3_d;
	logic signed [15:0] y1_q, y2_q, y3_q, y1_d, y2_d, y3_d, y_new;
	logic signed [27:0] acc;
	logic signed [15:0] cn [4];
	logic signed [7:0] bd [3];

	assign cn[0] = {coef_q[0], coef_q[1]};
	assign cn[1] = {coef_q[2], coef_q[3]};
	assign cn[2] = {coef_q[4], coef_q[5]};
	assign cn[3] = {coef_q[6], coef_q[7]};
	assign bd[0] = coef_q[8];
	assign bd[1] = coef_q[9];
	assign bd[2] = coef_q[10];

	// three zeros, three poles; the overflow saturates rather than wraps
	always_comb begin
		acc = 28'(cn[0] * err_sample) + 28'(cn[1] * e1_q) + 28'(cn[2] * e2_q)
			+ 28'(cn[3] * e3_q) - 28'(bd[0] * y1_q) - 28'(bd[1] * y2_q)
			- 28'(bd[2] * y3_q);
		if ((acc >>> sipwm_pkg::FILT_SHIFT) > 28'sh0007FFF) begin
			y_new = 16'sh7FFF;
		end else if ((acc >>> sipwm_pkg::FILT_SHIFT) < -28'sh0008000) begin
			y_new = -16'sh8000;
		end else begin
			y_new = 16'(acc >>> sipwm_pkg::FILT_SHIFT);
		end
		{e1_d, e2_d, e3_d} = {e1_q, e2_q, e3_q};
		{y1_d, y2_d, y3_d} = {y1_q, y2_q, y3_q};
		duty_d = duty_q;
		if (cyc_start) begin
			{e1_d, e2_d, e3_d} = {err_sample, e1_q, e2_q};
			{y1_d, y2_d, y3_d} = {y_new, y1_q, y2_q};
			if (lim_q[sipwm_pkg::SAT_EN_BIT] && err_sample > sipwm_pkg::SAT_WINDOW) begin
				duty_d = limit;
			end else if (lim_q[sipwm_pkg::SAT_EN_BIT] && err_sample < -sipwm_pkg::SAT_WINDOW) begin
				duty_d = 7'h00;
			end else if (y_new < 16'sh0000) begin
				duty_d = 7'h00;
			end else if (y_new > 16'(limit)) begin
				duty_d = limit;
			end else begin
				duty_d = 7'(y_new);
			end
		end else if (duty_q > limit) begin
			duty_d = limit;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			{e1_q, e2_q, e3_q} <= 24'h000000;
			{y1_q, y2_q, y3_q} <= 48'h000000000000;
			duty_q <= 7'h00;
		end else begin
			{e1_q, e2_q, e3_q} <= {e1_d, e2_d, e3_d};
			{y1_q, y2_q, y3_q} <= {y1_d, y2_d, y3_d};
			duty_q <= duty_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign pwm_out = pwm_q;
	assign duty_cmd = duty_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	cfg_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		strap_done_q && converter_on |=> $stable(cfg_q))
		else $error("phase config changed while converter on");
	rate_map_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cfg_q.rate == sipwm_pkg::RATE_1000K |=> per_q == sipwm_pkg::PER_1000K)
		else $error("rate code 010 did not give 1000 kHz period");
	rate_reserved_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cfg_q.rate > sipwm_pkg::RATE_1000K |=> $stable(per_q))
		else $error("reserved rate code moved the period");
	sync_align_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		sync_line && !sync_prev_q |=> cnt_q == 9'h000)
		else $error("counter not realigned on sync edge");
	phase_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(pwm_q) |-> $past(cnt_q) == $past(delay))
		else $error("on-time did not start at the lag point");
	duty_limit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		##1 duty_q <= $past(limit))
		else $error("duty exceeds limit");
	sat_high_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cyc_start && lim_q[7] && err_sample > sipwm_pkg::SAT_WINDOW |=> duty_q == $past(limit))
		else $error("saturation high did not force limit");
	sat_low_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cyc_start && lim_q[7] && err_sample < -sipwm_pkg::SAT_WINDOW |=> duty_q == 7'h00)
		else $error("saturation low did not force zero");
	strap_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!strap_done_q && !interleave_mode_pin |=> cfg_q.intl == 5'h00)
		else $error("strap low did not load zero lag");
	filter_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!cyc_start && duty_q <= limit |=> $stable(duty_q) || !rst_b)
		else $error("duty changed outside switching cycle start");
endmodule

/* File: include/sipwm_pkg.sv */
package sipwm_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_PHASE_CFG = 8'h00;
	localparam logic [7:0] ADDR_DUTY_LIM = 8'h01;
	localparam logic [7:0] ADDR_COEF_BASE = 8'h02; // four numerators as high/low pairs, then three denominators
	localparam logic [7:0] ADDR_DUTY_STAT = 8'h0D;
	localparam int NUM_COEF_BYTES = 11;
	// field positions
	localparam int RATE_MSB = 7;
	localparam int RATE_LSB = 5;
	localparam int INTL_MSB = 4;
	localparam int SAT_EN_BIT = 7;
	localparam int LIM_MSB = 6;
	// reset values
	localparam logic [2:0] RATE_RESET = 3'h0;
	localparam logic [7:0] DUTY_LIM_RESET = 8'h00;
	// frequency codes
	localparam logic [2:0] RATE_500K = 3'h0;
	localparam logic [2:0] RATE_750K = 3'h1;
	localparam logic [2:0] RATE_1000K = 3'h2;
	// timing
	localparam int CLK_HZ = 200000000;
	localparam int F500_HZ = 500000;
	localparam int F750_HZ = 750000;
	localparam int F1000_HZ = 1000000;
	localparam logic [8:0] PER_500K = 9'(CLK_HZ / F500_HZ);
	localparam logic [8:0] PER_750K = 9'(CLK_HZ / F750_HZ);
	localparam logic [8:0] PER_1000K = 9'(CLK_HZ / F1000_HZ);
	localparam int PHASE_SHIFT = 5; // 32 steps of 11.25 degrees
	localparam int DUTY_SHIFT = 7; // duty limit in 1/128 of a period
	localparam int FILT_SHIFT = 8; // filter coefficient fraction bits
	localparam logic signed [7:0] SAT_WINDOW = 8'sh20;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sipwm_req_s;
	typedef struct packed {
		logic [2:0] rate;
		logic [4:0] intl;
	} sipwm_cfg_s;
endpackage

/* File: verif/sipwm_mgr_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// power manager model: sync line and register port
// ----------------------------------------
module sipwm_mgr_model (
	input wire logic sys_clk,
	output sipwm_pkg::sipwm_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	output logic sync_line
);
	// bus idle and sync low from time zero; sync stands still between edges
	initial begin
		reg_req = '0;
		sync_line = 1'b0;
	end
	// one-cycle write strobe; lag codes 0Ah and 0Bh are never sent
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == sipwm_pkg::ADDR_PHASE_CFG && d[4:1] == 4'h5) return;
		@(posedge sys_clk);
		#1;
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		@(posedge sys_clk);
		#1;
		reg_req.wr = 1'b0;
	endtask
	// read data is registered, so it is taken one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_req.addr = a;
		@(posedge sys_clk);
		#1;
		d = reg_rdata;
	endtask
	task automatic sync_set(input logic v);
		@(posedge sys_clk);
		#1;
		sync_line = v;
	endtask
endmodule

/* File: verif/tb_sipwm_core.sv */
`timescale 1ns/1ps
module tb_sipwm_core;
	logic sys_clk, rst_b, converter_on, interleave_mode_pin, sync_line, pwm_out, low_ok;
	logic [4:0] addr_pins;
	logic [7:0] reg_rdata, rd_v;
	logic signed [7:0] err_sample;
	logic [6:0] duty_cmd;
	sipwm_pkg::sipwm_req_s reg_req;
	int n_errors, num_checks, cyc, hi, per, n, n0;
	int per_tab[3];
	int lag_tab[3];
	sipwm_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.sync_line(sync_line), .converter_on(converter_on),
		.interleave_mode_pin(interleave_mode_pin), .addr_pins(addr_pins),
		.err_sample(err_sample), .pwm_out(pwm_out), .duty_cmd(duty_cmd));
	sipwm_mgr_model mgr (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.sync_line(sync_line));
	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;
	// about 10k cycles expected; a stuck pwm wait ends here
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			finish_test();
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_cnt(input string nm, input int e, input int g);
		num_checks++;
		if (g != e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
		mgr.rd(a, rd_v);
		chk_reg(nm, e, rd_v);
	endtask
	// outputs are looked at one step after the edge, once they have settled
	task automatic wait_pwm(input logic v);
		while (pwm_out !== v) begin
			@(posedge sys_clk);
			#1;
		end
	endtask
	// on-time and rise-to-rise period in clock cycles
	task automatic meas();
		wait_pwm(1'b0);
		wait_pwm(1'b1);
		hi = 0;
		while (pwm_out === 1'b1) begin
			@(posedge sys_clk);
			#1;
			hi++;
		end
		per = hi;
		while (pwm_out !== 1'b1) begin
			@(posedge sys_clk);
			#1;
			per++;
		end
	endtask
	// phase writes only land with the output off, so stop, write, restart
	task automatic set_run(input logic [7:0] ph);
		@(posedge sys_clk);
		#1;
		converter_on = 1'b0;
		mgr.wr(sipwm_pkg::ADDR_PHASE_CFG, ph);
		@(posedge sys_clk);
		#1;
		converter_on = 1'b1;
	endtask
	// sync edge raised inside the off-time, then cycles until on-time starts
	task automatic lag_cnt(output int c);
		wait_pwm(1'b1);
		wait_pwm(1'b0);
		mgr.sync_set(1'b1);
		c = 0;
		while (pwm_out !== 1'b1) begin
			@(posedge sys_clk);
			#1;
			c++;
		end
		mgr.sync_set(1'b0);
	endtask
	// new error applied, then two full periods for the filter to settle
	task automatic err_duty(input logic [7:0] e, input logic [7:0] d, input string nm);
		@(posedge sys_clk);
		#1;
		err_sample = e;
		repeat (820) @(posedge sys_clk);
		#1;
		chk_reg(nm, d, {1'b0, duty_cmd});
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		converter_on = 1'b0;
		interleave_mode_pin = 1'b1;
		addr_pins = 5'h05;
		err_sample = 8'sh7F;
		per_tab = '{sipwm_pkg::CLK_HZ / sipwm_pkg::F500_HZ,
			sipwm_pkg::CLK_HZ / sipwm_pkg::F750_HZ, sipwm_pkg::CLK_HZ / sipwm_pkg::F1000_HZ};
		lag_tab = '{0, 8, 31};
		repeat (8) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		repeat (3) @(posedge sys_clk);
		rd_chk(sipwm_pkg::ADDR_PHASE_CFG, 8'h05, "phase_reset");
		rd_chk(sipwm_pkg::ADDR_DUTY_LIM, sipwm_pkg::DUTY_LIM_RESET, "limit_reset");
		rd_chk(8'h20, 8'h00, "unmapped");
		// unity c0, every other coefficient zero: duty follows the error
		for (int i = 0; i < sipwm_pkg::NUM_COEF_BYTES; i++) begin
			mgr.wr(sipwm_pkg::ADDR_COEF_BASE + 8'(i), 8'h00);
		end
		mgr.wr(sipwm_pkg::ADDR_COEF_BASE, 8'h01);
		// an address past the bank must neither land in it nor read from it
		mgr.wr(8'h12, 8'h55);
		rd_chk(8'h12, 8'h00, "coef_alias");
		rd_chk(sipwm_pkg::ADDR_COEF_BASE, 8'h01, "coef_c0h");
		rd_chk(sipwm_pkg::ADDR_COEF_BASE + 8'h0A, 8'h00, "coef_b3");
		mgr.wr(sipwm_pkg::ADDR_DUTY_LIM, 8'h40);
		rd_chk(sipwm_pkg::ADDR_DUTY_LIM, 8'h40, "limit");
		// each rate code, duty clamped to half a period
		for (int i = 0; i < 3; i++) begin
			set_run({3'(i), 5'h00});
			meas();
			chk_cnt("period", per_tab[i], per);
			chk_cnt("on_time", (per_tab[i] * 64) >> 7, hi);
		end
		chk_reg("duty_clamp", 8'h40, {1'b0, duty_cmd});
		set_run(8'h60);
		meas();
		chk_cnt("reserved_period", per_tab[2], per);
		mgr.wr(sipwm_pkg::ADDR_PHASE_CFG, 8'h00);
		rd_chk(sipwm_pkg::ADDR_PHASE_CFG, 8'h60, "locked_write");
		// lag steps relative to lag zero at 500 kHz
		for (int i = 0; i < 3; i++) begin
			set_run({3'h0, 5'(lag_tab[i])});
			lag_cnt(n);
			if (i == 0) n0 = n;
			chk_cnt("lag", (per_tab[0] * lag_tab[i]) >> 5, n - n0);
		end
		err_duty(8'h10, 8'h10, "in_window");
		err_duty(8'h21, 8'h21, "sat_off");
		// saturation tried only as on a low-voltage rail, limit kept near nominal
		mgr.wr(sipwm_pkg::ADDR_DUTY_LIM, 8'hC0);
		err_duty(8'h21, 8'h40, "sat_high");
		err_duty(8'hDF, 8'h00, "sat_low");
		err_duty(8'h10, 8'h10, "sat_inside");
		rd_chk(sipwm_pkg::ADDR_DUTY_STAT, 8'h10, "duty_stat");
		@(posedge sys_clk);
		#1;
		converter_on = 1'b0;
		repeat (3) @(posedge sys_clk);
		low_ok = 1'b1;
		repeat (800) begin
			@(posedge sys_clk);
			#1;
			if (pwm_out !== 1'b0) low_ok = 1'b0;
		end
		chk_reg("pwm_off", 8'h01, {7'h00, low_ok});
		// second reset with the mode pin low: the lag must load zero, not the address
		interleave_mode_pin = 1'b0;
		rst_b = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		repeat (3) @(posedge sys_clk);
		rd_chk(sipwm_pkg::ADDR_PHASE_CFG, 8'h00, "phase_strap_low");
		finish_test();
	end
endmodule
